//--- design/bbt_pkg.sv
`default_nettype none
package bbt_pkg;
  // Two-wire bus target address; the value is arbitrary
  localparam logic [6:0]  BBT_DEV_ADDR_DEF  = 7'h5A;
  localparam logic [3:0]  BBT_BYTE_BITS     = 4'h8;

  // Register offsets
  localparam logic [7:0]  BBT_ADDR_ILIM     = 8'h0B;
  localparam logic [7:0]  BBT_ADDR_TGT_LO   = 8'h0C;
  localparam logic [7:0]  BBT_ADDR_TGT_HI   = 8'h0D;
  localparam logic [7:0]  BBT_ADDR_CC_STAT  = 8'h21;
  localparam logic [7:0]  BBT_ADDR_FAULT    = 8'h78;
  localparam logic [7:0]  BBT_ADDR_STEP_CFG = 8'hD8;

  // Reset values
  localparam logic [7:0]  BBT_TGT_LO_RST    = 8'h58;
  localparam logic [3:0]  BBT_TGT_HI_RST    = 4'h2;
  localparam logic [7:0]  BBT_ILIM_RST      = 8'h64;
  localparam logic [7:0]  BBT_STEP_CFG_RST  = 8'h84;
  localparam logic [7:0]  BBT_STATUS_RST    = 8'h00;

  // Field positions
  localparam int          BBT_CC_BIT        = 6;
  localparam int          BBT_STEP_SEL_BIT  = 0;

  // Current limit: code in 0.5 mV units, flat from the saturation code
  localparam logic [7:0]  BBT_ILIM_SAT_CODE = 8'h8C;
  localparam logic [7:0]  BBT_ILIM_FLAT_TOP = 8'hC1;

  // Output target scaling and range, in mV
  localparam logic [16:0] BBT_STEP_20MV     = 17'h00014;
  localparam logic [16:0] BBT_STEP_10MV     = 17'h0000A;
  localparam logic [16:0] BBT_VOUT_MIN_MV   = 17'h00CE4;
  localparam logic [16:0] BBT_VOUT_MAX_MV   = 17'h0BB80;

  typedef enum logic [8:0] {
    BBT_IDLE     = 9'h001,
    BBT_ADDR     = 9'h002,
    BBT_ACK_ADDR = 9'h004,
    BBT_PTR      = 9'h008,
    BBT_ACK_PTR  = 9'h010,
    BBT_WDATA    = 9'h020,
    BBT_ACK_W    = 9'h040,
    BBT_RDATA    = 9'h080,
    BBT_ACK_R    = 9'h100
  } bbt_state_e;
endpackage
`default_nettype wire

//--- design/bbt_sync.sv
`default_nettype none
module bbt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_chk
    $error("bbt_sync WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

//--- design/bbt_ilim_map.sv
`default_nettype none
module bbt_ilim_map (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [7:0] code,
  output var  logic [7:0] half_mv,
  output var  logic       saturated
);
  import bbt_pkg::*;

  // Threshold rises 0.5 mV per code, then holds at the 70 mV ceiling
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      half_mv   <= BBT_ILIM_RST;
      saturated <= 1'b0;
    end else if (code >= BBT_ILIM_SAT_CODE) begin
      half_mv   <= BBT_ILIM_SAT_CODE;
      saturated <= 1'b1;
    end else begin
      half_mv   <= code;
      saturated <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_ilim_top_flat: assert property (code >= BBT_ILIM_FLAT_TOP |=> half_mv == 8'h8C)
    else $error("current limit not held at ceiling");
  a_ilim_linear: assert property (
    code < BBT_ILIM_SAT_CODE |=> half_mv == $past(code) && !saturated)
    else $error("current limit code not passed through");
  c_ilim_sat: cover property (code == 8'hFF ##1 saturated);
endmodule
`default_nettype wire

//--- design/bbt_regs.sv
// Behaviour
// - Limit codes from C1 up give 70 mV.
// - Target low byte, offset 0C, resets 58.
// - Target high nibble, offset 0D, resets 2.
// - Target spans 3.3 V to 48 V.
// - Step 20 or 10 mV from D8 select.
// - Unimplemented bits ignore writes, read zero.
// - Offset 21 bit 6 shows live CC limiting.
// - Fault summary byte at 78, resets 00.
// - Each fault bit reads 1 while present.
`default_nettype none
module bbt_regs #(
  parameter logic [6:0] DEV_ADDR = bbt_pkg::BBT_DEV_ADDR_DEF
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  input  wire logic        constant_current_active,
  input  wire logic [7:0]  fault_in,
  output var  logic [7:0]  current_limit_level,
  output var  logic [7:0]  ilim_half_mv,
  output var  logic        ilim_saturated,
  output var  logic [11:0] target_code,
  output var  logic [16:0] target_mv,
  output var  logic        target_clamped,
  output var  logic        step_10mv
);
  import bbt_pkg::*;

  bbt_state_e  state;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  ptr;
  logic        rw;
  logic        wr_stb;
  logic        scl_s;
  logic        sda_s;
  logic        scl_low_s;
  logic        sda_low_s;
  logic        cc_s;
  logic [7:0]  fault_s;
  logic        scl_d;
  logic        sda_d;
  logic        i2c_start;
  logic        i2c_stop;
  logic        scl_rise;
  logic        scl_fall;
  logic [7:0]  output_target_low;
  logic [3:0]  output_target_high;
  logic [7:0]  step_select_config;
  logic [7:0]  cc_limit_status;
  logic [7:0]  fault_summary_low;
  logic [7:0]  rd_data;
  logic [7:0]  rd_next;
  logic [16:0] raw_mv;

  if (DEV_ADDR == 7'h00) begin : g_chk
    $error("bbt_regs DEV_ADDR must not be the general call address");
  end

  // Every input pin except rst crosses two flip-flops before any logic reads it
  bbt_sync #(
    .WIDTH (11)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({~scl_in, ~sda_in, constant_current_active, fault_in}),
    .q       ({scl_low_s, sda_low_s, cc_s, fault_s})
  );

  // Bus pins pass inverted so a cleared synchroniser reads as an idle high bus
  assign scl_s = !scl_low_s;
  assign sda_s = !sda_low_s;

  bbt_ilim_map u_ilim (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .code      (current_limit_level),
    .half_mv   (ilim_half_mv),
    .saturated (ilim_saturated)
  );

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      BBT_ADDR_ILIM:     v = current_limit_level;
      BBT_ADDR_TGT_LO:   v = output_target_low;
      BBT_ADDR_TGT_HI:   v = {4'h0, output_target_high};
      BBT_ADDR_CC_STAT:  v = cc_limit_status;
      BBT_ADDR_FAULT:    v = fault_summary_low;
      BBT_ADDR_STEP_CFG: v = step_select_config;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  function automatic logic [16:0] scale_mv(input logic [11:0] c, input logic sel10);
    logic [16:0] step;
    step = sel10 ? BBT_STEP_10MV : BBT_STEP_20MV;
    return 17'({5'h00, c} * step);
  endfunction

  function automatic logic [16:0] clamp_mv(input logic [16:0] mv);
    logic [16:0] r;
    r = mv;
    if (mv < BBT_VOUT_MIN_MV) begin
      r = BBT_VOUT_MIN_MV;
    end else if (mv > BBT_VOUT_MAX_MV) begin
      r = BBT_VOUT_MAX_MV;
    end
    return r;
  endfunction

  assign rd_data   = read_reg(ptr);
  assign rd_next   = read_reg(8'(ptr + 8'h01));
  assign i2c_start = scl_s && sda_d && !sda_s;
  assign i2c_stop  = scl_s && !sda_d && sda_s;
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  // Open drain: the pin is only ever pulled low
  assign sda_out   = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus target: address, pointer, then data bytes with auto-increment
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state   <= BBT_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      sda_oe  <= 1'b0;
      wr_stb  <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (i2c_start) begin
        state   <= BBT_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (i2c_stop) begin
        state  <= BBT_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          BBT_IDLE: begin
            sda_oe <= 1'b0;
          end
          BBT_ADDR, BBT_PTR, BBT_WDATA: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= 4'(bit_cnt + 4'h1);
            end else if (scl_fall && bit_cnt == BBT_BYTE_BITS) begin
              bit_cnt <= 4'h0;
              sda_oe  <= 1'b1;
              if (state == BBT_ADDR) begin
                if (shift[7:1] == DEV_ADDR) begin
                  state <= BBT_ACK_ADDR;
                  rw    <= shift[0];
                end else begin
                  state  <= BBT_IDLE;
                  sda_oe <= 1'b0;
                end
              end else if (state == BBT_PTR) begin
                state <= BBT_ACK_PTR;
                ptr   <= shift;
              end else begin
                state  <= BBT_ACK_W;
                wr_stb <= 1'b1;
              end
            end
          end
          BBT_ACK_ADDR: begin
            if (scl_fall && rw) begin
              state   <= BBT_RDATA;
              shift   <= rd_data;
              sda_oe  <= !rd_data[7];
              bit_cnt <= 4'h1;
            end else if (scl_fall) begin
              state  <= BBT_PTR;
              sda_oe <= 1'b0;
            end
          end
          BBT_ACK_PTR, BBT_ACK_W: begin
            if (scl_fall) begin
              state  <= BBT_WDATA;
              sda_oe <= 1'b0;
              if (state == BBT_ACK_W) begin
                ptr <= 8'(ptr + 8'h01);
              end
            end
          end
          BBT_RDATA: begin
            if (scl_fall && bit_cnt == BBT_BYTE_BITS) begin
              state  <= BBT_ACK_R;
              sda_oe <= 1'b0;
            end else if (scl_fall) begin
              shift   <= {shift[6:0], 1'b0};
              sda_oe  <= !shift[6];
              bit_cnt <= 4'(bit_cnt + 4'h1);
            end
          end
          BBT_ACK_R: begin
            // A not-acknowledge ends the read; the host then sends stop
            if (scl_rise && sda_s) begin
              state <= BBT_IDLE;
            end else if (scl_fall) begin
              state   <= BBT_RDATA;
              ptr     <= 8'(ptr + 8'h01);
              shift   <= rd_next;
              sda_oe  <= !rd_next[7];
              bit_cnt <= 4'h1;
            end
          end
          default: begin
            state  <= BBT_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Writable registers; read-only offsets and upper target bits drop data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      output_target_low   <= BBT_TGT_LO_RST;
      output_target_high  <= BBT_TGT_HI_RST;
      current_limit_level <= BBT_ILIM_RST;
      step_select_config  <= BBT_STEP_CFG_RST;
    end else if (wr_stb) begin
      case (ptr)
        BBT_ADDR_TGT_LO:   output_target_low   <= shift;
        BBT_ADDR_TGT_HI:   output_target_high  <= shift[3:0];
        BBT_ADDR_ILIM:     current_limit_level <= shift;
        BBT_ADDR_STEP_CFG: step_select_config  <= shift;
        default:           ;
      endcase
    end
  end

  // Status bytes follow the synchronised inputs, no latching
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cc_limit_status   <= BBT_STATUS_RST;
      fault_summary_low <= BBT_STATUS_RST;
    end else begin
      cc_limit_status             <= BBT_STATUS_RST;
      cc_limit_status[BBT_CC_BIT] <= cc_s;
      fault_summary_low           <= fault_s;
    end
  end

  // Target path: code first, scaled and range-limited one cycle later
  assign raw_mv = scale_mv(target_code, step_10mv);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      target_code    <= {BBT_TGT_HI_RST, BBT_TGT_LO_RST};
      step_10mv      <= BBT_STEP_CFG_RST[BBT_STEP_SEL_BIT];
      target_mv      <= BBT_VOUT_MIN_MV;
      target_clamped <= 1'b0;
    end else begin
      target_code    <= {output_target_high, output_target_low};
      step_10mv      <= step_select_config[BBT_STEP_SEL_BIT];
      target_mv      <= clamp_mv(raw_mv);
      target_clamped <= clamp_mv(raw_mv) != raw_mv;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_tgt_lo_reset: assert property (
    disable iff (1'b0) rst |=> output_target_low == 8'h58)
    else $error("target low byte reset value wrong");
  a_tgt_hi_reset: assert property (
    disable iff (1'b0) rst |=> read_reg(8'h0D) == 8'h02)
    else $error("target high byte reset value wrong");
  a_tgt_lo_write: assert property (
    wr_stb && ptr == 8'h0C |=> output_target_low == $past(shift))
    else $error("target low byte write lost");
  a_hi_upper_zero: assert property (
    wr_stb && ptr == 8'h0D |=> read_reg(8'h0D) == {4'h0, $past(shift[3:0])})
    else $error("target high byte upper bits not zero");
  a_cc_live_bit: assert property (
    ##2 read_reg(8'h21) == {1'b0, $past(cc_s), 6'h00})
    else $error("constant current status not live");
  a_fault_follow: assert property (
    $stable(fault_s) [*2] |-> read_reg(8'h78) == fault_s)
    else $error("fault summary does not follow inputs");
  a_code_concat: assert property (
    ##1 target_code == {$past(output_target_high), $past(output_target_low)})
    else $error("target code not high nibble over low byte");
  // The scaled value lags the code by one cycle, so compare against the code before
  a_step_scale: assert property (
    !target_clamped && $stable(target_code) && $stable(step_10mv) |=> target_clamped ||
      target_mv == 17'($past(target_code) * ($past(step_10mv) ? 17'h0000A : 17'h00014)))
    else $error("target step scaling wrong");
  a_range_held: assert property (
    target_mv >= 17'h00CE4 && target_mv <= 17'h0BB80)
    else $error("target outside 3.3 V to 48 V");
  a_ack_driven: assert property (state == BBT_ACK_ADDR |-> sda_oe)
    else $error("address not acknowledged");

  c_write_lo: cover property (wr_stb && ptr == BBT_ADDR_TGT_LO);
  c_read_byte: cover property (state == BBT_RDATA ##[1:400] state == BBT_ACK_R);
  c_cc_active: cover property (cc_limit_status[BBT_CC_BIT]);
  c_step_10: cover property (step_10mv && !target_clamped);
endmodule
`default_nettype wire

//--- testbench/bbt_host_model.sv
`default_nettype none
// Bus host; SDA is open drain, pulled up on the wire, so the host only pulls low
module bbt_host_model #(
  parameter int         HALF = 10,
  parameter logic [6:0] DEV  = 7'h00
) (
  input  wire logic clk_sys,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_pull
);
  timeunit 1ns;
  timeprecision 1ps;

  // Ten-cycle phases keep well clear of the four-cycle minimum and keep the run short
  initial begin
    scl_out = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // SDA moves two cycles after SCL falls so the synchronised edges never coincide
  task automatic bit_x(input logic b, output logic r);
    tick(2);
    sda_pull <= ~b;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    r = sda_in;
    scl_out <= 1'b0;
  endtask

  task automatic start_cond();
    tick(2);
    sda_pull <= 1'b0;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b1;
    tick(HALF);
    scl_out <= 1'b0;
  endtask

  task automatic stop_cond();
    tick(2);
    sda_pull <= 1'b1;
    tick(HALF);
    scl_out <= 1'b1;
    tick(HALF);
    sda_pull <= 1'b0;
    tick(HALF);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask

  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d0,
                            input logic [7:0] d1, input int n, output logic ok);
    logic a0, a1, a2, a3;
    a3 = 1'b1;
    start_cond();
    send_byte({DEV, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(d0, a2);
    if (n > 1) send_byte(d1, a3);
    stop_cond();
    ok = a0 & a1 & a2 & a3;
  endtask

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start_cond();
    send_byte({DEV, 1'b0}, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte({DEV, 1'b1}, a2);
    recv_byte(1'b1, d);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Two-byte read exercises the pointer step after an acknowledged read byte
  task automatic read_pair(input logic [7:0] ptr, output logic [15:0] d, output logic ok);
    logic       a0, a1, a2;
    logic [7:0] lo;
    logic [7:0] hi;
    start_cond();
    send_byte({DEV, 1'b0}, a0);
    send_byte(ptr, a1);
    start_cond();
    send_byte({DEV, 1'b1}, a2);
    recv_byte(1'b0, lo);
    recv_byte(1'b1, hi);
    stop_cond();
    d = {hi, lo};
    ok = a0 & a1 & a2;
  endtask

  task automatic probe(input logic [6:0] addr, output logic ack);
    start_cond();
    send_byte({addr, 1'b0}, ack);
    stop_cond();
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bbt_pkg::*;

  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] wr;
    logic [7:0] rd;
  } bbt_row_s;

  logic        clk_sys  = 1'b0;
  logic        rst      = 1'b1;
  logic        cc       = 1'b0;
  logic [7:0]  fault_in = 8'h00;
  logic        scl;
  logic        host_pull;
  wire  logic  sda_wire;
  logic        sda_out;
  logic        sda_oe;
  logic [7:0]  current_limit_level;
  logic [7:0]  ilim_half_mv;
  logic        ilim_sat;
  logic [11:0] target_code;
  logic [16:0] target_mv;
  logic        target_clamped;
  logic        step_10mv;
  int          n_fail    = 0;
  int          tests_run = 0;

  bbt_row_s rows [7] = '{'{BBT_ADDR_TGT_LO, 8'hAB, 8'hAB}, '{BBT_ADDR_TGT_HI, 8'hF7, 8'h07},
                         '{BBT_ADDR_ILIM, 8'h90, 8'h90}, '{BBT_ADDR_STEP_CFG, 8'h85, 8'h85},
                         '{BBT_ADDR_CC_STAT, 8'hFF, 8'h00}, '{BBT_ADDR_FAULT, 8'hFF, 8'h00},
                         '{8'h40, 8'h55, 8'h00}};
  bbt_row_s rst_rows [4] = '{'{BBT_ADDR_TGT_LO, 8'h00, 8'h58}, '{BBT_ADDR_TGT_HI, 8'h00, 8'h02},
                             '{BBT_ADDR_CC_STAT, 8'h00, 8'h00}, '{BBT_ADDR_FAULT, 8'h00, 8'h00}};
  logic [7:0] lim [3] = '{8'h8B, 8'hC1, 8'hFF};

  always #10 clk_sys = ~clk_sys;

  // Open-drain wire with pull-up: low while either party pulls
  assign sda_wire = (host_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;

  bbt_host_model #(.HALF(10), .DEV(BBT_DEV_ADDR_DEF)) u_bbt_host_model (
    .clk_sys  (clk_sys),
    .sda_in   (sda_wire),
    .scl_out  (scl),
    .sda_pull (host_pull)
  );

  bbt_regs #(.DEV_ADDR(BBT_DEV_ADDR_DEF)) u_bbt_regs (
    .clk_sys                 (clk_sys),
    .rst                     (rst),
    .scl_in                  (scl),
    .sda_in                  (sda_wire),
    .sda_out                 (sda_out),
    .sda_oe                  (sda_oe),
    .constant_current_active (cc),
    .fault_in                (fault_in),
    .current_limit_level     (current_limit_level),
    .ilim_half_mv            (ilim_half_mv),
    .ilim_saturated          (ilim_sat),
    .target_code             (target_code),
    .target_mv               (target_mv),
    .target_clamped          (target_clamped),
    .step_10mv               (step_10mv)
  );

  function automatic logic [16:0] exp_mv(input logic [11:0] code, input logic s10);
    logic [16:0] v;
    v = code * (s10 ? 17'h0000A : 17'h00014);
    if (v < 17'h00CE4) v = 17'h00CE4;
    if (v > 17'h0BB80) v = 17'h0BB80;
    return v;
  endfunction

  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  initial begin
    logic [7:0]  d;
    logic        ok;
    logic [15:0] dd;
    do_reset();
    foreach (rows[i]) begin
      u_bbt_host_model.write_regs(rows[i].ptr, rows[i].wr, 8'h00, 1, ok);
      check(ok, 1'b1, "write ack");
      u_bbt_host_model.read_reg(rows[i].ptr, d, ok);
      check(ok, 1'b1, "ack");
      check(d, rows[i].rd, "readback");
    end
    check(target_code, 12'h7AB, "code");
    check(target_mv, exp_mv(12'h7AB, 1'b1), "mv at 10 mV step");
    u_bbt_host_model.write_regs(BBT_ADDR_TGT_LO, 8'h60, 8'h09, 2, ok);
    check(target_code, 12'h960, "pair code");
    check(target_mv, exp_mv(12'h960, 1'b1), "pair mv 10");
    u_bbt_host_model.read_pair(BBT_ADDR_TGT_LO, dd, ok);
    check(ok, 1'b1, "pair read ack");
    check(dd, 16'h0960, "pair read");
    u_bbt_host_model.write_regs(BBT_ADDR_STEP_CFG, 8'h84, 8'h00, 1, ok);
    check(step_10mv, 1'b0, "step select");
    check(target_mv, exp_mv(12'h960, 1'b0), "pair mv 20");
    // Deliberately below range to see the floor hold
    u_bbt_host_model.write_regs(BBT_ADDR_TGT_LO, 8'hA0, 8'h00, 2, ok);
    check(target_mv, 17'h00CE4, "floor");
    check(target_clamped, 1'b1, "floor flag");
    foreach (lim[i]) begin
      u_bbt_host_model.write_regs(BBT_ADDR_ILIM, lim[i], 8'h00, 1, ok);
      check(current_limit_level, lim[i], "limit reg");
      check(ilim_half_mv, (lim[i] < 8'h8C) ? lim[i] : 8'h8C, "limit");
      check(ilim_sat, lim[i] >= 8'h8C, "limit flag");
    end
    for (int i = 0; i < 8; i++) begin
      fault_in <= 8'h01 << i;
      cc <= i[0];
      repeat (8) @(posedge clk_sys);
      u_bbt_host_model.read_reg(BBT_ADDR_FAULT, d, ok);
      check(d, 8'h01 << i, "fault bit");
      u_bbt_host_model.read_reg(BBT_ADDR_CC_STAT, d, ok);
      check(d, {1'b0, i[0], 6'h00}, "cc status");
    end
    u_bbt_host_model.probe(7'h3B, ok);
    check(ok, 1'b0, "foreign address");
    fault_in <= 8'h00;
    cc <= 1'b0;
    do_reset();
    check(target_code, 12'h258, "reset code");
    check(target_mv, exp_mv(12'h258, 1'b0), "reset mv");
    foreach (rst_rows[i]) begin
      u_bbt_host_model.read_reg(rst_rows[i].ptr, d, ok);
      check(d, rst_rows[i].rd, "reset value");
    end
    final_report();
  end

  // A hang ends the run through the same report
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    $display("wrong value at %0t: run did not finish", $time);
    final_report();
  end
endmodule
`default_nettype wire
